// *** hw/epd_lut_pkg.sv ***
/*
 * Shared constants and types for the waveform table and set selection block.
 * Assumes a single 200 MHz clock domain and a plain register port.
 */
package epd_lut_pkg;

    // Clock and frame timing
    localparam int CLK_PERIOD_NS     = 5;
    localparam int FRAME_PERIOD_NS   = 20_000_000;
    localparam int FRAME_CYCLES_DEF  = FRAME_PERIOD_NS / CLK_PERIOD_NS;

    // Display RAM geometry
    localparam int       ROW_BYTES   = 19;
    localparam int       RAM_BYTES   = 4750;
    localparam logic [4:0] X_LAST    = 5'h12;
    localparam logic [7:0] Y_LAST    = 8'hF9;

    // Waveform table layout
    localparam int LUT_BYTES         = 32;
    localparam int GROUPS            = 5;
    localparam int PHASES            = 10;
    localparam int TIMING_BASE       = 16;
    localparam int SET_COUNT         = 7;
    localparam int RANGE_COUNT       = 6;
    localparam int BANK_BYTES        = 256;
    localparam int RANGE_BASE        = 224;
    localparam int RANGE_STRIDE      = 3;
    localparam int SET29_BYTE        = 29;
    localparam int POS_LEVEL_BYTE    = 30;
    localparam int SET31_BYTE        = 31;

    // Source level codes
    localparam logic [1:0] CODE_GND  = 2'h0;
    localparam logic [1:0] CODE_POS  = 2'h1;
    localparam logic [1:0] CODE_NEG  = 2'h2;

    // Temperature register
    localparam logic [11:0] TEMP_RESET = 12'h7F0;

    // Register offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_TEMP_MSB  = 8'h04;
    localparam logic [7:0] OFS_TEMP_LSB  = 8'h08;
    localparam logic [7:0] OFS_XCNT      = 8'h0C;
    localparam logic [7:0] OFS_YCNT      = 8'h10;
    localparam logic [7:0] OFS_RAM_DATA  = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam logic [7:0] OFS_TEMP_DEG  = 8'h1C;
    localparam logic [7:0] OFS_SETTINGS  = 8'h20;

    // Control bit positions
    localparam int CTRL_START        = 0;
    localparam int CTRL_PROG         = 1;
    localparam int CTRL_SPARE        = 2;

    typedef struct packed {
        logic signed [11:0] low;
        logic signed [11:0] high;
    } temp_bounds_t;

    typedef logic [3:0][1:0] src_levels_t;

endpackage : epd_lut_pkg

// *** hw/temp_range_search.sv ***
/*
 * Walks the temperature ranges in order and records the selected set.
 * Assumes bounds stay stable while a search runs.
 */
`timescale 1ns/1ps
module temp_range_search
    import epd_lut_pkg::*;
#(
    parameter int RANGES = RANGE_COUNT
)(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    // Search request
    input  wire logic                start,
    input  wire logic signed [11:0]  temp,
    input  wire temp_bounds_t        bounds [RANGES],
    // Result
    output logic [2:0]               selSet,
    output logic                     done
);

    initial if (RANGES < 1 || RANGES > 7) $error("RANGES out of range");

    logic [2:0]   idx_r;
    logic         running_r;
    temp_bounds_t cur;
    logic         hit;

    assign cur = bounds[idx_r - 3'h1];
    // Signed compare, low bound exclusive, high inclusive
    assign hit = (temp > cur.low) && (temp <= cur.high);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx_r     <= 3'h1;
            running_r <= 1'b0;
            selSet    <= 3'h0;
            done      <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (start)
            begin
                selSet    <= 3'h0;
                idx_r     <= 3'h1;
                running_r <= 1'b1;
            end
            else if (running_r)
            begin
                if (hit)
                    selSet <= idx_r;
                idx_r <= idx_r + 3'h1;
                if (idx_r == 3'(RANGES))
                begin
                    running_r <= 1'b0;
                    done      <= 1'b1;
                end
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_default_set_zero: assert property (ce && start |=> selSet == 3'h0)
        else $error("search did not start from set zero");
    a_last_match_kept: assert property (ce && running_r && hit |=> selSet == $past(idx_r))
        else $error("matching range not recorded");
    a_no_hit_keeps: assert property (ce && running_r && !hit && !start |=> $stable(selSet))
        else $error("selection changed without a match");

endmodule : temp_range_search

// *** hw/waveform_phase_seq.sv ***
/*
 * Steps through the five groups of A/B phases of a loaded waveform table.
 * Assumes the table stays stable while a run is active.
 */
`timescale 1ns/1ps
module waveform_phase_seq
    import epd_lut_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYCLES_DEF
)(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    // Control
    input  wire logic                      start,
    input  wire logic                      runEn,
    input  wire logic [LUT_BYTES*8-1:0]    lut,
    // Drive
    output src_levels_t                    levels,
    output logic                           done
);

    initial if (FRAME_CYCLES < 1) $error("FRAME_CYCLES must be positive");

    localparam int FW = $clog2(FRAME_CYCLES + 1);

    logic [2:0]    grp_r;
    logic          sub_r;
    logic [5:0]    rep_r;
    logic [4:0]    phCnt_r;
    logic [FW-1:0] frame_r;
    logic          active_r;
    logic [3:0]    phase;
    logic [7:0]    lvlByte, tmByte, repLo, repHi;
    logic [4:0]    len;
    logic [5:0]    repCount;
    logic          tick, phaseEnd;

    assign phase    = {grp_r, sub_r};
    assign lvlByte  = lut[8*phase +: 8];
    assign tmByte   = lut[8*(TIMING_BASE + phase) +: 8];
    assign repLo    = lut[8*(TIMING_BASE + 2*grp_r) +: 8];
    assign repHi    = lut[8*(TIMING_BASE + 2*grp_r + 1) +: 8];
    assign len      = tmByte[4:0];
    assign repCount = {repHi[7:5], repLo[7:5]};
    assign tick     = runEn && (frame_r == FW'(FRAME_CYCLES - 1));
    // Zero length ends the phase at once
    assign phaseEnd = active_r && ((len == 5'h0) || (tick && phCnt_r == len - 5'h1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            grp_r    <= 3'h0;
            sub_r    <= 1'b0;
            rep_r    <= 6'h0;
            phCnt_r  <= 5'h0;
            frame_r  <= '0;
            active_r <= 1'b0;
            levels   <= '0;
            done     <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (start)
            begin
                {grp_r, sub_r, rep_r, phCnt_r, frame_r} <= '0;
                active_r <= 1'b1;
            end
            else if (active_r)
            begin
                if (runEn)
                    frame_r <= tick ? '0 : frame_r + FW'(1);
                // Skipped phase drives ground; each level is registered and still shows one cycle into the next phase
                levels <= (len != 5'h0) ? lvlByte : '0;
                if (phaseEnd)
                begin
                    phCnt_r <= 5'h0;
                    sub_r   <= ~sub_r;
                    if (sub_r)
                    begin
                        if (rep_r == repCount)
                        begin
                            rep_r <= 6'h0;
                            grp_r <= grp_r + 3'h1;
                            if (grp_r == 3'(GROUPS - 1))
                            begin
                                active_r <= 1'b0;
                                done     <= 1'b1;
                                levels   <= '0;
                            end
                        end
                        else
                            rep_r <= rep_r + 6'h1;
                    end
                end
                else if (tick)
                    phCnt_r <= phCnt_r + 5'h1;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_zero_phase_skip: assert property (ce && active_r && !start && len == 5'h0 |=> phase != $past(phase) || !active_r)
        else $error("zero length phase not skipped");
    a_level_held: assert property (ce && active_r && !start && !phaseEnd && len != 5'h0 ##1 ce && active_r |-> ##1 ($stable(levels) || done))
        else $error("level moved inside a phase");
    a_strap_frozen: assert property (ce && !runEn && !start |=> $stable(frame_r))
        else $error("frame timing ran without internal clock");

endmodule : waveform_phase_seq

// *** hw/epd_waveform_lut_select.sv ***
/*
 * Display RAM, waveform store with spare bank, temperature register,
 * set search, table load and phase sequencing.
 * Assumes a register master that obeys one-cycle strobes on clk.
 */
// Operation
// - RAM holds 19 bytes per row, X 00h-12h, Y 00h-F9h, bit 7 lowest source
// - Waveform timing runs only when the clock strap is tied high
// - Waveform has ten phases: five groups of A and B
// - Phase lasts length times frame period; length zero skips it
// - Six-bit repeat count repeats the A/B pair; zero means once
// - Level code 00 ground, 01 positive, 10 negative source level
// - Selected source level is constant for the whole phase
// - Table is 32 bytes; bytes 0-9 hold four codes, 11 at top
// - Bytes 16-25 pair lengths; even holds repeat 2:0, odd repeat 5:3
// - Bytes 10-15 and 26-28 zero; 29, 30, 31 hold settings
// - Store holds option, common value, source value, 7 sets, 6 ranges
// - Each store byte has a spare at plus 256, filled in write order
// - Set m loads when low bound < temperature <= high bound
// - Set zero is selected before any comparison
// - Ranges 1 to 6 compared in order; last match wins
// - No matching range selects set zero
// - Temperature and selected table kept in volatile registers
// - Bit 11 clear: positive degrees equal value over 16
// - Bit 11 set: negative two's complement, magnitude over 16
// - Temperature written as MSB and LSB, low nibble zero, resets 127
// - Update loads temperature, then table, then drives phases
`timescale 1ns/1ps
module epd_waveform_lut_select
    import epd_lut_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYCLES_DEF
)(
    // Clock, reset, enable
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Strap
    input  wire logic         clockSourceStrap,
    // Register port
    input  wire logic [7:0]   addr,
    input  wire logic [31:0]  wdata,
    input  wire logic         we,
    input  wire logic         re,
    output logic [31:0]       rdata,
    // Status and drive
    output logic              busy,
    output logic [2:0]        selectedSetPointer,
    output src_levels_t       sourceLevelCode
);

    initial if (FRAME_CYCLES < 1) $error("FRAME_CYCLES must be positive");

    typedef enum logic [2:0] {IDLE, LOAD_TEMP, SEARCH, LOAD_LUT, RUN} upd_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [7:0]  dispRam [RAM_BYTES];
    logic [7:0]  nvm     [2*BANK_BYTES];
    logic [7:0]  lutMem  [LUT_BYTES];

    upd_state_t          state_r;
    logic [11:0]         temp_r;
    logic signed [11:0]  workTemp_r;
    logic [4:0]          x_r;
    logic [7:0]          y_r;
    logic                progEn_r, spare_r;
    logic                strapInt_r, strapSeen_r;
    logic [4:0]          ldCnt_r;
    logic                searchGo_r, seqGo_r;
    logic                fmtErr_r;
    logic [2:0]          selSet;
    logic                searchDone, seqDone;
    src_levels_t         seqLevels;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic        wrCtrl, wrMsb, wrLsb, wrX, wrY, wrRam;
    logic        startReq;
    logic [12:0] linAddr;
    logic        lastX, lastY;
    logic [8:0]  progAddr;
    logic [8:0]  lutAddr;
    logic [31:0] rdMux;
    logic [LUT_BYTES*8-1:0] lutFlat;
    temp_bounds_t bounds [RANGE_COUNT];
    logic [11:0] tempMag;
    logic [15:0] tempDeg;
    logic        zeroBytesBad;

    assign wrCtrl   = we && addr == OFS_CTRL;
    assign wrMsb    = we && addr == OFS_TEMP_MSB;
    assign wrLsb    = we && addr == OFS_TEMP_LSB;
    assign wrX      = we && addr == OFS_XCNT;
    assign wrY      = we && addr == OFS_YCNT;
    assign wrRam    = we && addr == OFS_RAM_DATA;
    assign startReq = wrCtrl && wdata[CTRL_START] && state_r == IDLE;

    // Row-major byte index
    assign linAddr  = 13'(y_r) * 13'(ROW_BYTES) + 13'(x_r);
    assign lastX    = x_r == X_LAST;
    assign lastY    = y_r == Y_LAST;
    // Spare copy sits one bank above
    assign progAddr = {spare_r, linAddr[7:0]};
    assign lutAddr  = {spare_r, 8'(32'(selSet) * LUT_BYTES) + 8'(ldCnt_r)};

    // Range bounds, 24 bits each packed as low then high
    genvar gi;
    generate
        for (gi = 0; gi < RANGE_COUNT; gi++)
        begin : g_bounds
            localparam int B = RANGE_BASE + gi * RANGE_STRIDE;
            assign bounds[gi].low  = {nvm[{spare_r, 8'(B)}], nvm[{spare_r, 8'(B + 1)}][7:4]};
            assign bounds[gi].high = {nvm[{spare_r, 8'(B + 1)}][3:0], nvm[{spare_r, 8'(B + 2)}]};
        end
        for (gi = 0; gi < LUT_BYTES; gi++)
        begin : g_flat
            assign lutFlat[8*gi +: 8] = lutMem[gi];
        end
    endgenerate

    // Reserved table bytes must read zero
    assign zeroBytesBad = (lutMem[10] | lutMem[11] | lutMem[12] | lutMem[13] | lutMem[14]
                          | lutMem[15] | lutMem[26] | lutMem[27] | lutMem[28]) != 8'h00;

    // Sign and magnitude view of temperature
    assign tempMag = temp_r[11] ? 12'(-temp_r) : temp_r;
    assign tempDeg = {temp_r[11], 3'h0, tempMag};

    always_comb
    begin
        rdMux = 32'h0000_0000;
        if (addr == OFS_CTRL)
            rdMux = {29'h0, spare_r, progEn_r, 1'b0};
        else if (addr == OFS_TEMP_MSB)
            rdMux = {24'h0, temp_r[11:4]};
        else if (addr == OFS_TEMP_LSB)
            rdMux = {24'h0, temp_r[3:0], 4'h0};
        else if (addr == OFS_XCNT)
            rdMux = {27'h0, x_r};
        else if (addr == OFS_YCNT)
            rdMux = {24'h0, y_r};
        else if (addr == OFS_RAM_DATA)
            rdMux = {24'h0, dispRam[linAddr]};
        else if (addr == OFS_STATUS)
            rdMux = {26'h0, fmtErr_r, strapInt_r, selSet, busy};
        else if (addr == OFS_TEMP_DEG)
            rdMux = {16'h0, tempDeg};
        else if (addr == OFS_SETTINGS)
            rdMux = {16'h0, lutMem[SET31_BYTE][3:0], lutMem[POS_LEVEL_BYTE][4:0],
                     lutMem[SET29_BYTE][6:0]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 32'h0000_0000;
        else if (ce)
            rdata <= re ? rdMux : 32'h0000_0000;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            temp_r   <= TEMP_RESET;
            progEn_r <= 1'b0;
            spare_r  <= 1'b0;
        end
        else if (ce)
        begin
            if (wrMsb)
                temp_r[11:4] <= wdata[7:0];
            // LSB byte carries the fraction in its high nibble
            if (wrLsb)
                temp_r[3:0] <= wdata[7:4];
            if (wrCtrl)
            begin
                progEn_r <= wdata[CTRL_PROG];
                spare_r  <= wdata[CTRL_SPARE];
            end
        end
    end

    // Strap caught once after reset release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strapInt_r  <= 1'b0;
            strapSeen_r <= 1'b0;
        end
        else if (ce && !strapSeen_r)
        begin
            strapInt_r  <= clockSourceStrap;
            strapSeen_r <= 1'b1;
        end
    end

    // Address counters; wrap keeps programming in one pass
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            x_r <= 5'h0;
            y_r <= 8'h00;
        end
        else if (ce)
        begin
            if (wrX)
                x_r <= (wdata[4:0] > X_LAST) ? X_LAST : wdata[4:0];
            else if (wrRam)
                x_r <= lastX ? 5'h0 : x_r + 5'h1;
            if (wrY)
                y_r <= (wdata[7:0] > Y_LAST) ? Y_LAST : wdata[7:0];
            else if (wrRam && lastX)
                y_r <= lastY ? 8'h00 : y_r + 8'h01;
        end
    end

    // Arrays carry no reset, as in real macro storage
    always_ff @(posedge clk)
    begin
        if (ce && wrRam)
            dispRam[linAddr] <= wdata[7:0];
    end

    always_ff @(posedge clk)
    begin
        if (ce && wrRam && progEn_r && linAddr < 13'(BANK_BYTES))
            nvm[progAddr] <= wdata[7:0];
    end

    always_ff @(posedge clk)
    begin
        if (ce && state_r == LOAD_LUT)
            lutMem[ldCnt_r] <= nvm[lutAddr];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Update sequence

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r    <= IDLE;
            workTemp_r <= TEMP_RESET;
            ldCnt_r    <= 5'h0;
            searchGo_r <= 1'b0;
            seqGo_r    <= 1'b0;
            busy       <= 1'b0;
            fmtErr_r   <= 1'b0;
        end
        else if (ce)
        begin
            searchGo_r <= 1'b0;
            seqGo_r    <= 1'b0;
            case (state_r)
                IDLE:
                    if (startReq)
                    begin
                        state_r <= LOAD_TEMP;
                        busy    <= 1'b1;
                    end
                LOAD_TEMP:
                begin
                    workTemp_r <= temp_r;
                    searchGo_r <= 1'b1;
                    state_r    <= SEARCH;
                end
                SEARCH:
                    if (searchDone)
                    begin
                        ldCnt_r <= 5'h0;
                        state_r <= LOAD_LUT;
                    end
                LOAD_LUT:
                begin
                    ldCnt_r <= ldCnt_r + 5'h1;
                    if (ldCnt_r == 5'(LUT_BYTES - 1))
                    begin
                        seqGo_r <= 1'b1;
                        state_r <= RUN;
                    end
                end
                RUN:
                begin
                    fmtErr_r <= zeroBytesBad;
                    if (seqDone)
                    begin
                        state_r <= IDLE;
                        busy    <= 1'b0;
                    end
                end
                default:
                    state_r <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            selectedSetPointer <= 3'h0;
            sourceLevelCode    <= '0;
        end
        else if (ce)
        begin
            if (searchDone)
                selectedSetPointer <= selSet;
            sourceLevelCode <= seqLevels;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Submodules

    temp_range_search #(
        .RANGES (RANGE_COUNT)
    ) u_search (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .start  (searchGo_r),
        .temp   (workTemp_r),
        .bounds (bounds),
        .selSet (selSet),
        .done   (searchDone)
    );

    waveform_phase_seq #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_seq (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .start  (seqGo_r),
        .runEn  (strapInt_r),
        .lut    (lutFlat),
        .levels (seqLevels),
        .done   (seqDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_start;
        ce && startReq;
    endsequence

    sequence s_load_order;
        ##1 state_r == LOAD_TEMP ##1 state_r == SEARCH;
    endsequence

    a_update_order: assert property (s_start |-> s_load_order)
        else $error("update did not load temperature before search");
    a_temp_lsb_write: assert property (ce && wrLsb |=> temp_r[3:0] == $past(wdata[7:4]))
        else $error("temperature fraction not written");
    a_row_wrap: assert property (ce && wrRam && !wrX && lastX |=> x_r == 5'h0)
        else $error("column counter did not wrap after 12h");
    a_read_one_cycle: assert property (ce && !re |=> rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_load_len: assert property (ce && state_r == LOAD_LUT && ldCnt_r == 5'h1F |=> state_r == RUN)
        else $error("table load not 32 bytes");

endmodule : epd_waveform_lut_select

// *** tb/host_model.sv ***
/*
 * Host model: drives the register port, one strobe every other cycle.
 * Assumes read data stand only in the cycle after the read strobe.
 */
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic [7:0]       addr,
    output logic [31:0]      wdata,
    output logic             we,
    output logic             re,
    input  wire logic [31:0] rdata
);
    import epd_lut_pkg::*;
    initial
    begin
        addr = 8'h00;
        wdata = 32'h0000_0000;
        we = 1'b0;
        re = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // Store writes need full windows and counters at zero first
    task automatic setup();
        wr(OFS_CTRL, 32'h0000_0002);
        wr(OFS_XCNT, 32'h0000_0000);
        wr(OFS_YCNT, 32'h0000_0000);
    endtask : setup
endmodule : host_model

// *** tb/epd_waveform_lut_select_bench.sv ***
/*
 * Bench: programs the store, then runs updates at several temperatures.
 * Assumes the design asserts its own rules; ce is tied high.
 */
`timescale 1ns/1ps
module epd_waveform_lut_select_bench
    import epd_lut_pkg::*;
;
    localparam int FC = 4;
    // Ranges 1..6 as {low,high}, deliberately unsorted
    localparam logic [143:0] RNG = 144'h0001_9010_07F0_E000_007F_F7FF_7FF7_FF7F_F7FF;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        strap = 1'b1;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
    logic [31:0] rdata;
    logic        busy;
    logic [2:0]  selectedSetPointer;
    src_levels_t sourceLevelCode;
    logic [31:0] d;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;
    always #2.5 clk = ~clk;
    host_model host (.clk(clk), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata));
    epd_waveform_lut_select #(.FRAME_CYCLES(FC)) uut (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .clockSourceStrap(strap),
        .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
        .busy(busy), .selectedSetPointer(selectedSetPointer),
        .sourceLevelCode(sourceLevelCode));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask : check
    task automatic results();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    // Set m: phase 0A level 24h for two frames, settings mark m
    function automatic logic [7:0] storeByte(input int i);
        if (i >= 224)
            return (i < 242) ? RNG[143-8*(i-224) -: 8] : 8'h00;
        case (i % 32)
            0: return 8'h24;
            16: return 8'h02;
            29: return 8'((i / 32) + 1);
            30: return 8'(i / 32);
            default: return 8'h00;
        endcase
    endfunction : storeByte
    task automatic testRegs();
        host.rd(OFS_TEMP_MSB, d); check("tempMsb", d, 32'h0000_007F);
        host.rd(OFS_TEMP_LSB, d); check("tempLsb", d, 32'h0000_0000);
        host.rd(OFS_TEMP_DEG, d); check("tempDeg", d, 32'h0000_07F0);
        host.rd(8'hFC, d); check("unmapped", d, 32'h0000_0000);
        host.rd(OFS_STATUS, d); check("strap", d[4], 32'h0000_0001);
        host.wr(OFS_TEMP_MSB, 32'h0000_00E7);
        host.rd(OFS_TEMP_DEG, d); check("negDeg", d, 32'h0000_8190);
        host.wr(OFS_TEMP_LSB, 32'h0000_0020);
        host.rd(OFS_TEMP_LSB, d); check("lsbWrite", d, 32'h0000_0020);
        host.rd(OFS_TEMP_DEG, d); check("negFrac", d, 32'h0000_818E);
        host.wr(OFS_TEMP_LSB, 32'h0000_0000);
        $display("registers done");
    endtask : testRegs
    task automatic testProgram();
        host.setup();
        // Whole store: sets 0 to 6, then the range bytes from 224
        for (int i = 0; i < 256; i++)
            host.wr(OFS_RAM_DATA, {24'h00_0000, storeByte(i)});
        host.rd(OFS_XCNT, d); check("xcnt", d, 32'h0000_0009);
        host.rd(OFS_YCNT, d); check("ycnt", d, 32'h0000_000D);
        host.wr(OFS_CTRL, 32'h0000_0000);
        $display("program done");
    endtask : testProgram
    task automatic testSearch();
        logic [7:0] msb [5] = '{8'h19, 8'h08, 8'h00, 8'h7F, 8'h80};
        int exp [5] = '{2, 1, 3, 2, 0};
        int n;
        int hits;
        for (int k = 0; k < 5; k++)
        begin
            host.wr(OFS_TEMP_MSB, {24'h00_0000, msb[k]});
            host.wr(OFS_CTRL, 32'h0000_0001);
            n = 0;
            hits = 0;
            // Let busy settle after the start edge
            #1;
            while (busy === 1'b1 && n < 3000)
            begin
                @(posedge clk);
                #1 n++;
                if (sourceLevelCode === 8'h24) hits++;
            end
            check("busyEnd", busy, 32'h0000_0000);
            check("levelTime", hits, 2 * FC);
            check("selSet", selectedSetPointer, exp[k]);
            host.rd(OFS_SETTINGS, d); check("settings", d, (exp[k] << 7) | (exp[k] + 1));
            host.rd(OFS_STATUS, d); check("status", d, 32'h0000_0010 | (exp[k] << 1));
        end
        $display("search done");
    endtask : testSearch
    // Strap low after a reset between updates: frames never advance
    task automatic testStrap();
        rst_n <= 1'b0;
        strap <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        host.rd(OFS_STATUS, d); check("strapLow", d, 32'h0000_0000);
        host.wr(OFS_CTRL, 32'h0000_0001);
        repeat (100) @(posedge clk);
        #1 check("frozen", {busy, sourceLevelCode}, 32'h0000_0124);
        check("resetSel", selectedSetPointer, 32'h0000_0002);
        rst_n <= 1'b0;
        strap <= 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        $display("strap done");
    endtask : testStrap
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            miscompares++;
            results();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        testRegs();
        testProgram();
        testSearch();
        testStrap();
        results();
    end
endmodule : epd_waveform_lut_select_bench
